//--- pkg/ssao_pkg.sv
// constants and widths shared by the stereo serial audio transmitter
package ssao_pkg;

    // -------------------------------------------------------------
    // sample and frame layout
    // -------------------------------------------------------------
    localparam int SAMPLE_BITS = 16;
    localparam int FRAME_BITS = 2 * SAMPLE_BITS;
    localparam int SLOT_W = $clog2(FRAME_BITS);
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 5'h00;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 5'h1F;
    localparam logic [SLOT_W-1:0] SLOT_RIGHT = 5'h10;

    // -------------------------------------------------------------
    // frame timing, scaled from the link oscillator
    // -------------------------------------------------------------
    localparam int LINK_REF_KHZ = 12800;
    localparam int FRAME_KHZ = 50;
    localparam int LINK_CLOCKS_PER_FRAME = LINK_REF_KHZ / FRAME_KHZ;
    localparam int HALF_BIT_CLOCKS = LINK_CLOCKS_PER_FRAME / (2 * FRAME_BITS);
    localparam int DIV_W = $clog2(HALF_BIT_CLOCKS);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_BIT_CLOCKS - 1);

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [SAMPLE_BITS-1:0] SAMPLE_RESET = 16'h0000;
    localparam logic [FRAME_BITS-1:0] FRAME_RESET = 32'h0000_0000;
    localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;

endpackage : ssao_pkg

//--- logic/ssao_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module ssao_sync (
    input wire logic clock,
    input wire logic nrst,
    input wire logic level_in,
    output logic level_out
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // -------------------------------------------------------------
    // two stages
    // -------------------------------------------------------------
    always_comb begin
        meta_d = level_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign level_out = sync_q;

endmodule : ssao_sync

//--- logic/ssao_top.sv
// stereo serial audio transmitter: sample handshake and serializer
`timescale 1ns/1ps

// Contract
// - device makes the bit clock; every data bit is timed by it.
// - word select is high for the right word, low for the left.
// - each frame holds one left word then one right word.
// - each word is 16 bits, least significant bit first.
// - frame rate is 50kHz at 12.8MHz, scaling with the oscillator.
// - words carry the full mix of all sixteen voices.
// - only the inter-IC sound framing exists; nothing selects another.
module ssao_top
    import ssao_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic link_clock,
    input wire logic [SAMPLE_BITS-1:0] mix_left,
    input wire logic [SAMPLE_BITS-1:0] mix_right,
    input wire logic mix_valid,
    output logic mix_ready,
    output logic serial_bit_clock,
    output logic word_select,
    output logic serial_data
);

    // -------------------------------------------------------------
    // reset release into the system domain
    // -------------------------------------------------------------
    logic sys_nrst;

    ssao_sync u_sys_reset (
        .clock(clock),
        .nrst(nrst),
        .level_in(1'b1),
        .level_out(sys_nrst)
    );

    // -------------------------------------------------------------
    // system domain: take one mixed stereo sample
    // -------------------------------------------------------------
    logic [SAMPLE_BITS-1:0] hold_left_q;
    logic [SAMPLE_BITS-1:0] hold_left_d;
    logic [SAMPLE_BITS-1:0] hold_right_q;
    logic [SAMPLE_BITS-1:0] hold_right_d;
    logic req_q;
    logic req_d;
    logic ready_q;
    logic ready_d;
    logic ack_sys;

    always_comb begin
        hold_left_d = hold_left_q;
        hold_right_d = hold_right_q;
        req_d = req_q;
        if (mix_valid && ready_q) begin
            // mixed voices only, no per-voice path
            hold_left_d = mix_left;
            hold_right_d = mix_right;
            req_d = ~req_q;
        end
        ready_d = (ack_sys == req_d);
    end

    always_ff @(posedge clock or negedge sys_nrst) begin
        if (!sys_nrst) begin
            hold_left_q <= SAMPLE_RESET;
            hold_right_q <= SAMPLE_RESET;
            req_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            hold_left_q <= hold_left_d;
            hold_right_q <= hold_right_d;
            req_q <= req_d;
            ready_q <= ready_d;
        end
    end

    assign mix_ready = ready_q;

    // -------------------------------------------------------------
    // crossings
    // -------------------------------------------------------------
    logic link_nrst;
    logic req_link;
    logic ack_q;

    ssao_sync u_link_reset (
        .clock(link_clock),
        .nrst(nrst),
        .level_in(1'b1),
        .level_out(link_nrst)
    );

    ssao_sync u_req_sync (
        .clock(link_clock),
        .nrst(link_nrst),
        .level_in(req_q),
        .level_out(req_link)
    );

    ssao_sync u_ack_sync (
        .clock(clock),
        .nrst(sys_nrst),
        .level_in(ack_q),
        .level_out(ack_sys)
    );

    // -------------------------------------------------------------
    // link domain: accept the held sample
    // -------------------------------------------------------------
    logic [SAMPLE_BITS-1:0] pend_left_q;
    logic [SAMPLE_BITS-1:0] pend_left_d;
    logic [SAMPLE_BITS-1:0] pend_right_q;
    logic [SAMPLE_BITS-1:0] pend_right_d;
    logic ack_d;

    always_comb begin
        pend_left_d = pend_left_q;
        pend_right_d = pend_right_q;
        ack_d = ack_q;
        if (req_link != ack_q) begin
            // held words are stable while the request is open
            pend_left_d = hold_left_q;
            pend_right_d = hold_right_q;
            ack_d = req_link;
        end
    end

    always_ff @(posedge link_clock or negedge link_nrst) begin
        if (!link_nrst) begin
            pend_left_q <= SAMPLE_RESET;
            pend_right_q <= SAMPLE_RESET;
            ack_q <= 1'b0;
        end else begin
            pend_left_q <= pend_left_d;
            pend_right_q <= pend_right_d;
            ack_q <= ack_d;
        end
    end

    // -------------------------------------------------------------
    // link domain: bit clock
    // -------------------------------------------------------------
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic sck_q;
    logic sck_d;
    logic fall;

    always_comb begin
        // half bit period from the oscillator
        div_d = div_q + DIV_W'(1);
        sck_d = sck_q;
        if (div_q == DIV_LAST) begin
            sck_d = ~sck_q; // device-made bit clock
        end
        fall = (div_q == DIV_LAST) && sck_q;
    end

    always_ff @(posedge link_clock or negedge link_nrst) begin
        if (!link_nrst) begin
            div_q <= DIV_RESET;
            sck_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sck_q <= sck_d;
        end
    end

    // -------------------------------------------------------------
    // link domain: serializer
    // -------------------------------------------------------------
    logic [SLOT_W-1:0] slot_q;
    logic [SLOT_W-1:0] slot_d;
    logic [FRAME_BITS-1:0] shift_q;
    logic [FRAME_BITS-1:0] shift_d;
    logic ws_q;
    logic ws_d;
    logic sd_q;
    logic sd_d;

    always_comb begin
        slot_d = slot_q;
        shift_d = shift_q;
        ws_d = ws_q;
        sd_d = sd_q;
        if (fall) begin
            // outputs move only on the falling bit clock
            slot_d = slot_q + SLOT_W'(1);
            sd_d = shift_q[0]; // least significant bit first
            if (slot_d == SLOT_FIRST) begin
                // left word in the low half, right in the high
                shift_d = {pend_right_q, pend_left_q};
            end else begin
                shift_d = {1'b0, shift_q[FRAME_BITS-1:1]};
            end
            // select leads data by one bit, fixed framing
            ws_d = (slot_d >= SLOT_RIGHT); // high means right word
        end
    end

    always_ff @(posedge link_clock or negedge link_nrst) begin
        if (!link_nrst) begin
            slot_q <= SLOT_LAST;
            shift_q <= FRAME_RESET;
            ws_q <= 1'b1;
            sd_q <= 1'b0;
        end else begin
            slot_q <= slot_d;
            shift_q <= shift_d;
            ws_q <= ws_d;
            sd_q <= sd_d;
        end
    end

    // -------------------------------------------------------------
    // link outputs, each straight from a flop
    // -------------------------------------------------------------
    assign serial_bit_clock = sck_q;
    assign word_select = ws_q;
    assign serial_data = sd_q;

endmodule : ssao_top

//--- test/ssao_top_monitor.sv
// link-side timing checks for the serial audio transmitter
`timescale 1ns/1ps
module ssao_top_monitor (
    input wire logic nrst,
    input wire logic link_clock,
    input wire logic serial_bit_clock,
    input wire logic word_select,
    input wire logic serial_data
);
    default clocking @(posedge link_clock); endclocking
    default disable iff (!nrst);
    a_bck_steady: assert property ($changed(serial_bit_clock) |=>
        $stable(serial_bit_clock)[*3]) else $error("bck glitch");
    a_bck_toggle: assert property ($changed(serial_bit_clock) |->
        ##4 $changed(serial_bit_clock)) else $error("bck rate");
    a_data_on_fall: assert property ($changed(serial_data) |->
        $fell(serial_bit_clock)) else $error("data edge");
    a_ws_on_fall: assert property ($changed(word_select) |->
        $fell(serial_bit_clock)) else $error("ws edge");
    a_right_len: assert property ($rose(word_select) |->
        ##128 $fell(word_select)) else $error("right length");
    a_left_len: assert property ($fell(word_select) |->
        ##128 $rose(word_select)) else $error("left length");
    a_frame_rate: assert property ($rose(word_select) |->
        ##256 $rose(word_select)) else $error("frame rate");
    a_data_hold: assert property ($rose(serial_bit_clock) |->
        $stable(serial_data)[*4]) else $error("data hold");
endmodule : ssao_top_monitor
bind ssao_top ssao_top_monitor mon (
    .nrst(nrst),
    .link_clock(link_clock),
    .serial_bit_clock(serial_bit_clock),
    .word_select(word_select),
    .serial_data(serial_data)
);

//--- test/ssao_dac_model.sv
// converter model: collects words on bit clock rise
`timescale 1ns/1ps
module ssao_dac_model (
    input wire logic serial_bit_clock,
    input wire logic word_select,
    input wire logic serial_data,
    output logic [15:0] got_left,
    output logic [15:0] got_right,
    output int n_right
);
    logic [15:0] shift_q = 16'h0000;
    logic ws_q = 1'b1;
    always @(posedge serial_bit_clock) begin
        shift_q = {serial_data, shift_q[15:1]};
        if (word_select !== ws_q && ws_q) begin
            got_right = shift_q;
            n_right++;
        end else if (word_select !== ws_q) begin
            got_left = shift_q;
        end
        ws_q = word_select;
    end
endmodule : ssao_dac_model

//--- test/ssao_top_bench.sv
// self-checking bench for the serial audio transmitter
`timescale 1ns/1ps
module ssao_top_bench;
    logic clock = 1'b0, link_clock = 1'b0, nrst = 1'b0, mix_valid = 1'b0;
    logic [15:0] mix_left = 16'h0000, mix_right = 16'h0000;
    logic [15:0] got_left, got_right;
    logic mix_ready, serial_bit_clock, word_select, serial_data;
    int n_right, fails = 0, n_tests = 0;
    ssao_top DUT (
        .clock(clock),
        .nrst(nrst),
        .link_clock(link_clock),
        .mix_left(mix_left),
        .mix_right(mix_right),
        .mix_valid(mix_valid),
        .mix_ready(mix_ready),
        .serial_bit_clock(serial_bit_clock),
        .word_select(word_select),
        .serial_data(serial_data)
    );
    ssao_dac_model dac (
        .serial_bit_clock(serial_bit_clock),
        .word_select(word_select),
        .serial_data(serial_data),
        .got_left(got_left),
        .got_right(got_right),
        .n_right(n_right)
    );
    initial forever #25 clock = ~clock;
    initial #7.5 forever #16 link_clock = ~link_clock;
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("%0d checks, %0d wrong", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    task automatic send(logic [15:0] l, logic [15:0] r, int n);
        while (mix_ready !== 1'b1) begin
            @(negedge clock);
        end
        mix_left = l;
        mix_right = r;
        mix_valid = 1'b1;
        @(negedge clock);
        mix_valid = 1'b0;
        check({31'h0000_0000, mix_ready}, 32'h0000_0000);
        repeat (n) @(n_right);
        @(negedge clock);
    endtask : send
    task automatic t_words;
        send(16'hFFFF, 16'h0001, 0);
        send(16'h1234, 16'hF00D, 3);
        check({got_left, got_right}, 32'h1234_F00D);
    endtask : t_words
    task automatic t_reset;
        nrst = 1'b0;
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        send(16'h00FF, 16'hFF00, 3);
        check({got_left, got_right}, 32'h00FF_FF00);
    endtask : t_reset
    initial begin
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        t_words;
        t_reset;
        stop_test;
    end
    initial begin
        #1_000_000;
        fails++;
        stop_test;
    end
endmodule : ssao_top_bench
